// ==== hw/epdd_pin_cell.sv ====
// Purpose: one pin of the port: output driver and read-back select
// Assumes: pin input synchronous to aclk
// Notes: purely combinational, registers live in the top
`timescale 1ns/1ps
`default_nettype none
module epdd_pin_cell
   import epdd_pkg::*;
(
   input  wire logic latch_bit,   // stored data latch bit
   input  wire logic dir_bit,     // one = output
   input  wire logic pin_level,   // external pin level
   output wire logic drive_en,    // output enable next value
   output wire logic drive_val,   // output level next value
   output wire logic read_bit     // bit seen on a data read
);
   // =====================================================
   // driver and read mux
   assign drive_en  = dir_bit;
   assign drive_val = latch_bit;
   assign read_bit  = dir_bit ? latch_bit : pin_level;
endmodule : epdd_pin_cell
`default_nettype wire

// ==== hw/epdd_pkg.sv ====
// Purpose: constants for the eight-pin port with data latch and direction register
// Assumes: registers reached over AXI4-Lite, one aligned 32-bit word each
// Notes: offsets and reset values below are local choices
//
// Notes on behaviour
// - data read returns pin level for inputs
// - data read returns latch bit for outputs
// - byte write updates all eight latch bits
// - output pins drive their latch bit
// - direction one is output, zero is input
// - direction register reads back as all ones
// - input turning output drives latch one edge after the direction register loads
package epdd_pkg;
   // =====================================================
   // register map
   localparam logic [3:0]  EPDD_OFF_DATA  = 4'h0;   // data latch / pin read
   localparam logic [3:0]  EPDD_OFF_DIR   = 4'h4;   // direction, write-only
   // =====================================================
   // reset values and read constants
   localparam logic [7:0]  EPDD_RST_DATA  = 8'h00;  // latch after reset
   localparam logic [7:0]  EPDD_RST_DIR   = 8'h00;  // all pins input after reset
   localparam logic [7:0]  EPDD_DIR_RDVAL = 8'hff;  // direction read value
   localparam logic [1:0]  EPDD_RESP_OK   = 2'b00;  // OKAY
   localparam logic [1:0]  EPDD_RESP_ERR  = 2'b10;  // SLVERR for unmapped
endpackage : epdd_pkg

// ==== hw/epdd_port.sv ====
// Purpose: eight-pin port with data latch and direction register on AXI4-Lite
// Assumes: single clock aclk at 25 MHz, synchronous active-low reset
// Notes: pin outputs registered, so a register write shows on pins one edge later
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module epdd_port
   import epdd_pkg::*;
(
   input  wire logic        aclk,           // system clock
   input  wire logic        aresetn,        // synchronous reset, active low
   input  wire logic [3:0]  s_axi_awaddr,   // write address
   input  wire logic        s_axi_awvalid,  // write address valid
   output logic             s_axi_awready,  // write address ready
   input  wire logic [31:0] s_axi_wdata,    // write data
   input  wire logic [3:0]  s_axi_wstrb,    // write byte strobes
   input  wire logic        s_axi_wvalid,   // write data valid
   output logic             s_axi_wready,   // write data ready
   output logic [1:0]       s_axi_bresp,    // write response
   output logic             s_axi_bvalid,   // write response valid
   input  wire logic        s_axi_bready,   // write response ready
   input  wire logic [3:0]  s_axi_araddr,   // read address
   input  wire logic        s_axi_arvalid,  // read address valid
   output logic             s_axi_arready,  // read address ready
   output logic [31:0]      s_axi_rdata,    // read data
   output logic [1:0]       s_axi_rresp,    // read response
   output logic             s_axi_rvalid,   // read data valid
   input  wire logic        s_axi_rready,   // read data ready
   input  wire logic [7:0]  port_pin_in,    // external pin levels
   output logic [7:0]       port_pin_out,   // pin output levels
   output logic [7:0]       port_pin_oe     // pin output enables, high drives
);
   // =====================================================
   // registers
   logic [7:0]  data_latch_r;   // port_pin_data_latch
   logic [7:0]  data_latch_nxt; // next latch value
   logic [7:0]  dir_r;          // port_pin_direction
   logic [7:0]  dir_nxt;        // next direction value
   logic        aw_held_r;      // write address captured
   logic [3:0]  aw_addr_r;      // captured write address
   logic        w_held_r;       // write data captured
   logic [7:0]  w_byte_r;       // captured low data byte
   logic        w_lane_r;       // low byte strobe captured
   logic [7:0]  read_bits;      // per-pin read-back
   logic [7:0]  drive_en;       // per-pin enable next
   logic [7:0]  drive_val;      // per-pin level next
   logic [7:0]  dir_prev_r;     // direction one edge ago, for checks
   logic [7:0]  dir_rise;       // direction bits that just turned output

   // =====================================================
   // write channel decode
   // a write completes only once both halves are held and no response
   // is pending, so at most one write is ever in flight
   wire         aw_take   = s_axi_awvalid & s_axi_awready;       // address accepted
   wire         w_take    = s_axi_wvalid & s_axi_wready;         // data accepted
   wire         wr_go     = aw_held_r & w_held_r & ~s_axi_bvalid;// both halves present
   wire         wr_data   = wr_go & (aw_addr_r == EPDD_OFF_DATA);// data latch hit
   wire         wr_dir    = wr_go & (aw_addr_r == EPDD_OFF_DIR); // direction hit
   wire         wr_mapped = wr_data | wr_dir;                     // any mapped hit

   // whole byte replaces latch, input bits included
   assign data_latch_nxt = (wr_data & w_lane_r) ? w_byte_r : data_latch_r;
   // direction changes take effect on the write
   assign dir_nxt = (wr_dir & w_lane_r) ? w_byte_r : dir_r;

   // =====================================================
   // read channel decode
   wire         ar_take  = s_axi_arvalid & s_axi_arready;                 // read accepted
   // low address bits are ignored, as on the write side
   wire [3:0]   ar_addr  = {s_axi_araddr[3:2], 2'b00};                    // aligned read address
   wire         rd_data  = ar_addr == EPDD_OFF_DATA;                      // data read
   wire         rd_dir   = ar_addr == EPDD_OFF_DIR;                       // direction read
   // the direction register is write-only, so it always reads as ones
   wire [7:0]   rd_byte  = rd_data ? read_bits : (rd_dir ? EPDD_DIR_RDVAL : 8'h00);
   // unmapped addresses answer with an error and read as zero
   wire [1:0]   rd_resp  = (rd_data | rd_dir) ? EPDD_RESP_OK : EPDD_RESP_ERR;

   // =====================================================
   // per-pin cells
   // one cell per pin: driver enable, driver level and read select
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pin
         epdd_pin_cell u_cell (
            .latch_bit (data_latch_r[gi]),
            .dir_bit   (dir_r[gi]),
            .pin_level (port_pin_in[gi]),
            .drive_en  (drive_en[gi]),
            .drive_val (drive_val[gi]),
            .read_bit  (read_bits[gi])
         );
      end
   endgenerate

   // =====================================================
   // port registers
   // latch and direction load on a write hit with the low byte strobe set and hold otherwise
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_latch_r <= EPDD_RST_DATA;
         dir_r        <= EPDD_RST_DIR;
      end else begin
         data_latch_r <= data_latch_nxt;
         dir_r        <= dir_nxt;
      end
   end

   // pin drivers follow latch and direction
   // registered so the pins never glitch while the bus decodes;
   // the cost is one edge between a register write and the pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_pin_oe  <= 8'h00;
         port_pin_out <= 8'h00;
      end else begin
         port_pin_oe  <= drive_en;
         port_pin_out <= drive_val & drive_en;
      end
   end

   // =====================================================
   // write address and data capture, either order
   // each ready drops once its half is taken and stays low until the response is gone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r     <= 1'b0;
         aw_addr_r     <= 4'h0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_held_r & ~aw_take & ~s_axi_bvalid;
         if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
      end
   end

   // write data capture: only the low byte and its strobe are kept
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r     <= 1'b0;
         w_byte_r     <= 8'h00;
         w_lane_r     <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= ~w_held_r & ~w_take & ~s_axi_bvalid;
         if (w_take) begin
            w_held_r <= 1'b1;
            w_byte_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // write response
   // the response stands until the master raises bready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= EPDD_RESP_OK;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? EPDD_RESP_OK : EPDD_RESP_ERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // =====================================================
   // read path: data sampled at the address handshake
   // a pin that moves while rvalid waits does not change the answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= EPDD_RESP_OK;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_resp;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // =====================================================
   // check helpers: the direction one edge ago, to spot bits turning output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dir_prev_r <= EPDD_RST_DIR;   // matches the direction after reset
      end else begin
         dir_prev_r <= dir_r;          // one edge behind the direction
      end
   end
   assign dir_rise = dir_r & ~dir_prev_r;  // input to output this cycle

   // =====================================================
   // assertions
   // all checks sleep in reset; most look one edge past their trigger, a_dir_write two edges, a_wr_refuse and a_rd_refuse the same edge
   property p_in_pin_read;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && rd_data) |=> (s_axi_rdata[7:0] & ~$past(dir_r)) ==
                               ($past(port_pin_in) & ~$past(dir_r));
   endproperty
   a_in_pin_read: assert property (p_in_pin_read) else $error("input pin read wrong");

   property p_out_pin_read;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && rd_data) |=> (s_axi_rdata[7:0] & $past(dir_r)) ==
                               ($past(data_latch_r) & $past(dir_r));
   endproperty
   a_out_pin_read: assert property (p_out_pin_read) else $error("latch read wrong");

   property p_byte_write;
      @(posedge aclk) disable iff (!aresetn)
      (wr_data && w_lane_r) |=> data_latch_r == $past(w_byte_r);
   endproperty
   a_byte_write: assert property (p_byte_write) else $error("latch not written");

   property p_out_drive;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> (port_pin_out & $past(dir_r)) == ($past(data_latch_r) & $past(dir_r));
   endproperty
   a_out_drive: assert property (p_out_drive) else $error("pin level not latch");

   property p_dir_write;
      @(posedge aclk) disable iff (!aresetn)
      (wr_dir && w_lane_r) |=> ##1 port_pin_oe == $past(w_byte_r, 2);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction not applied");

   property p_dir_read;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && rd_dir) |=> s_axi_rdata == 32'h0000_00ff;
   endproperty
   a_dir_read: assert property (p_dir_read) else $error("direction read not ones");

   property p_turn_out;
      @(posedge aclk) disable iff (!aresetn)
      (|dir_rise) |=>
         ((port_pin_oe & $past(dir_rise)) == $past(dir_rise)) &&
         ((port_pin_out & $past(dir_rise)) == ($past(data_latch_r) & $past(dir_rise)));
   endproperty
   a_turn_out: assert property (p_turn_out) else $error("turned output not driving");

   property p_in_quiet;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> ((port_pin_oe | port_pin_out) & ~$past(dir_r)) == 8'h00;
   endproperty
   a_in_quiet: assert property (p_in_quiet) else $error("input pin driven");

   property p_bresp_bound;
      @(posedge aclk) disable iff (!aresetn)
      wr_go |=> s_axi_bvalid;
   endproperty
   a_bresp_bound: assert property (p_bresp_bound) else $error("no write response");

   property p_read_ok;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && (rd_data || rd_dir)) |=> s_axi_rvalid && s_axi_rresp == EPDD_RESP_OK;
   endproperty
   a_read_ok: assert property (p_read_ok) else $error("mapped read not answered okay");

   property p_bad_read;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && !rd_data && !rd_dir) |=>
         s_axi_rvalid && s_axi_rdata == 32'h0000_0000 && s_axi_rresp == EPDD_RESP_ERR;
   endproperty
   a_bad_read: assert property (p_bad_read) else $error("unmapped read not refused");

   property p_bad_write;
      @(posedge aclk) disable iff (!aresetn)
      (wr_go && !wr_mapped) |=> s_axi_bresp == EPDD_RESP_ERR &&
         data_latch_r == $past(data_latch_r) && dir_r == $past(dir_r);
   endproperty
   a_bad_write: assert property (p_bad_write) else $error("unmapped write had effect");

   property p_no_lane;
      @(posedge aclk) disable iff (!aresetn)
      (wr_mapped && !w_lane_r) |=> s_axi_bresp == EPDD_RESP_OK &&
         data_latch_r == $past(data_latch_r) && dir_r == $past(dir_r);
   endproperty
   a_no_lane: assert property (p_no_lane) else $error("write without low lane had effect");

   property p_wr_refuse;
      @(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_wr_refuse: assert property (p_wr_refuse) else $error("write taken during response");

   property p_rd_refuse;
      @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_rd_refuse: assert property (p_rd_refuse) else $error("read taken during answer");

   c_data_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_data);
   c_dir_write:  cover property (@(posedge aclk) disable iff (!aresetn) wr_dir);
   c_mixed_read: cover property (@(posedge aclk) disable iff (!aresetn)
                                 ar_take && rd_data && dir_r != 8'h00 && dir_r != 8'hff);
   c_bad_addr:   cover property (@(posedge aclk) disable iff (!aresetn) ar_take && !rd_data && !rd_dir);
   c_turn_out:   cover property (@(posedge aclk) disable iff (!aresetn) |dir_rise);
endmodule : epdd_port
`default_nettype wire

// ==== tb/epdd_pin_model.sv ====
// Purpose: far-side sources on the eight port pins
// Assumes: external sources stay connected, the port wins where it drives
// Notes: the resolved level is fed back to the port pin inputs
`timescale 1ns/1ps
`default_nettype none
module epdd_pin_model (
   input  wire logic [7:0] pin_oe,   // port drive enables
   input  wire logic [7:0] pin_out,  // port drive levels
   input  wire logic [7:0] ext_lvl,  // external source levels
   output wire logic [7:0] pin_lvl   // resolved wire level
);
   // =====================================================
   // wire resolution: driven pins show the port, others the source
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : epdd_pin_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the eight-pin port
// Assumes: AXI4-Lite master tasks, pin sources in epdd_pin_model
// Notes: random bytes from a fixed seed, bit operations done as software would
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import epdd_pkg::*;
   logic             aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;  // bus drive
   logic [3:0]       awaddr, araddr, wstrb;  // addresses and strobes
   logic [31:0]      wdata, rd_v;            // write data, read result
   logic [1:0]       rsp;                    // last response
   logic [7:0]       ext, lat, dir;          // sources and software shadows
   wire logic [7:0]  lvl, oe, pout;          // pin wires
   wire logic        awready, wready, bvalid, arready, rvalid;  // slave handshakes
   wire logic [1:0]  bresp, rresp;           // slave responses
   wire logic [31:0] rdata;                  // slave read data
   int               n_errors, compares;     // verdict counters
   epdd_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .port_pin_in(lvl), .port_pin_out(pout), .port_pin_oe(oe));
   epdd_pin_model pin_u (.pin_oe(oe), .pin_out(pout), .ext_lvl(ext), .pin_lvl(lvl));
   // =====================================================
   // clock, 40 ns period
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // =====================================================
   // compare, verdict and expectation helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic results;
      if (n_errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   function automatic logic [31:0] expv(input logic [7:0] l, d, e);
      return {24'h0, (l & d) | (e & ~d)};  // inputs show pins, outputs show latch
   endfunction : expv
   // =====================================================
   // bus master: write, both halves offered together
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
      int i;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= {24'h0, d};
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;  // address taken
         if (wready) wvalid <= 1'b0;    // data taken
         if (bvalid) break;             // response taken here
      end
      rsp    = bresp;
      bready <= 1'b0;
      if (i == 50) begin
         n_errors++;
         results();
      end
   endtask : wr
   // bus master: read
   task automatic rd(input logic [3:0] a);
      int i;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;  // address taken
         if (rvalid) break;             // data taken here
      end
      rd_v   = rdata;
      rsp    = rresp;
      rready <= 1'b0;
      if (i == 50) begin
         n_errors++;
         results();
      end
   endtask : rd
   // pins settle one edge after the register edge
   task automatic pins(input logic [7:0] e_oe, input logic [7:0] e_out);
      repeat (2) @(posedge aclk);
      #1;
      chk({24'h0, oe}, {24'h0, e_oe});
      chk({24'h0, pout}, {24'h0, e_out});
   endtask : pins
   // =====================================================
   // main sequence
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wstrb, wdata} = '0;
      ext = 8'h40;
      aresetn = 1'b0;
      void'($urandom(32'h4505));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(EPDD_OFF_DIR);
      chk(rd_v, 32'h000000ff);
      rd(EPDD_OFF_DATA);
      chk(rd_v, 32'h00000040);
      wr(EPDD_OFF_DATA, 8'h80, 4'hf);
      chk({30'h0, rsp}, {30'h0, EPDD_RESP_OK});
      wr(EPDD_OFF_DIR, 8'h3f, 4'hf);
      pins(8'h3f, 8'h00);
      // bit set done as read, modify, write of the whole byte
      rd(EPDD_OFF_DATA);
      chk(rd_v, 32'h00000040);
      wr(EPDD_OFF_DATA, rd_v[7:0] | 8'h01, 4'hf);
      pins(8'h3f, 8'h01);
      // bit clear on the direction byte read back as ones turns pins 6 and 7 into outputs and pin 0 into an input
      rd(EPDD_OFF_DIR);
      chk(rd_v, 32'h000000ff);
      wr(EPDD_OFF_DIR, rd_v[7:0] & 8'hfe, 4'hf);
      pins(8'hfe, 8'h40);
      // ignored strobe, unmapped write and read
      wr(EPDD_OFF_DATA, 8'hff, 4'h0);
      chk({30'h0, rsp}, {30'h0, EPDD_RESP_OK});
      rd(EPDD_OFF_DATA);
      chk(rd_v, expv(8'h41, 8'hfe, 8'h40));
      wr(4'h8, 8'h5a, 4'hf);
      chk({30'h0, rsp}, {30'h0, EPDD_RESP_ERR});
      rd(4'hc);
      chk({30'h0, rsp}, {30'h0, EPDD_RESP_ERR});
      chk(rd_v, 32'h0);
      // random bytes written whole from the shadow copies
      repeat (30) begin
         lat = 8'($urandom);
         dir = 8'($urandom);
         ext <= 8'($urandom);
         wr(EPDD_OFF_DATA, lat, 4'hf);
         wr(EPDD_OFF_DIR, dir, 4'hf);
         pins(dir, lat & dir);
         rd(EPDD_OFF_DATA);
         chk(rd_v, expv(lat, dir, ext));
         rd(EPDD_OFF_DIR);
         chk(rd_v, 32'h000000ff);
      end
      // reset in mid-run: every pin back to input, data reads show the sources
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      pins(8'h00, 8'h00);
      rd(EPDD_OFF_DATA);
      chk(rd_v, expv(lat, 8'h00, ext));
      results();
   end
endmodule : tb_top
`default_nettype wire
